// file: core/hub_port_io_gpio_ctrl.sv
// receiver port, io supply and gpio0 output control with an ahb-lite slave
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps

module hub_port_io_gpio_ctrl
  import hub_port_io_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic              io_level_detected,
  input  wire logic [7:0]        pin_in,
  input  wire logic [15:0]       rx_remote_gpio,
  input  wire logic [3:0]        rx_lock,
  input  wire logic [3:0]        rx_pass,
  input  wire logic [3:0]        rx_frame_valid,
  input  wire logic [3:0]        rx_line_valid,
  input  wire logic              frame_sync_pulse,
  input  wire logic              tx_frame_valid,
  input  wire logic              tx_line_valid,
  input  wire logic              tx_synchronized,
  input  wire logic              tx_interrupt,
  output logic [3:0]             receiver_enable,
  output logic [3:0]             chan_target_port_select,
  output logic                   io_level_select,
  output logic [1:0]             supply_mode,
  output logic [7:0]             pin_input_enable,
  output logic                   pin0_out,
  output logic                   pin0_oe
);

  // stored fields
  logic [3:0] rx_enable_r;
  logic [3:0] target_select_r;
  logic       level_wr_r;
  logic       override_r;
  logic [1:0] mode_wr_r;
  logic [7:0] input_enable_r;
  logic [2:0] out_select_r;
  logic [2:0] out_source_r;
  logic       out_value_r;
  logic       out_enable_r;

  // data phase state
  logic              wr_pend_r;
  logic [ADDR_W-1:0] wr_addr_r;

  // address phase decode
  wire addr_valid = hsel && hready &&
                    (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  wire rd_take    = addr_valid && !hwrite;
  wire wr_take    = addr_valid && hwrite;

  // data phase write strobes
  wire wr_rx   = wr_pend_r && (wr_addr_r == ADDR_W'(ADDR_RX_PORT_CTRL));
  wire wr_io   = wr_pend_r && (wr_addr_r == ADDR_W'(ADDR_IO_SUPPLY_CTRL));
  wire wr_inen = wr_pend_r && (wr_addr_r == ADDR_W'(ADDR_PIN_INPUT_EN));
  wire wr_out  = wr_pend_r && (wr_addr_r == ADDR_W'(ADDR_PIN0_OUT_CTRL));

  // next values of the stored fields
  wire [3:0] target_select_nxt =
    wr_rx ? hwdata[TGT_SEL_LSB +: 4] : target_select_r;
  wire [3:0] rx_enable_nxt =
    wr_rx ? hwdata[RX_EN_LSB +: 4] : rx_enable_r;
  wire       level_wr_nxt  = wr_io ? hwdata[LEVEL_BIT] : level_wr_r;
  wire       override_nxt  = wr_io ? hwdata[OVERRIDE_BIT] : override_r;
  wire [1:0] mode_wr_nxt   = wr_io ? hwdata[MODE_LSB +: 2] : mode_wr_r;
  wire [7:0] input_enable_nxt = wr_inen ? hwdata[7:0] : input_enable_r;
  wire [2:0] out_select_nxt =
    wr_out ? hwdata[OUT_SEL_LSB +: 3] : out_select_r;
  wire [2:0] out_source_nxt =
    wr_out ? hwdata[OUT_SRC_LSB +: 3] : out_source_r;
  wire       out_value_nxt  = wr_out ? hwdata[OUT_VAL_BIT] : out_value_r;
  wire       out_enable_nxt = wr_out ? hwdata[OUT_EN_BIT] : out_enable_r;

  // effective supply controls, from detection unless overridden
  wire       level_eff_nxt =
    override_nxt ? level_wr_nxt : io_level_detected;
  wire [1:0] mode_detected =
    io_level_detected ? MODE_3V3 : MODE_1V8;
  wire [1:0] mode_eff_nxt =
    override_nxt ? mode_wr_nxt : mode_detected;

  // pin levels seen through the input buffers
  wire [7:0] pin_levels = pin_in & input_enable_nxt;

  // register read images, built from next values so a read right after
  // a write to the same register sees the new contents
  wire [7:0] rx_image = {target_select_nxt, rx_enable_nxt};
  wire [7:0] io_image =
    {level_eff_nxt, override_nxt, mode_eff_nxt, IO_RESERVED_VALUE};
  wire [7:0] out_image =
    {out_select_nxt, out_source_nxt, out_value_nxt, out_enable_nxt};

  wire [ADDR_W-1:0] rd_addr = haddr;
  wire hit_rx   = rd_addr == ADDR_W'(ADDR_RX_PORT_CTRL);
  wire hit_io   = rd_addr == ADDR_W'(ADDR_IO_SUPPLY_CTRL);
  wire hit_sts  = rd_addr == ADDR_W'(ADDR_PIN_LEVEL_STS);
  wire hit_inen = rd_addr == ADDR_W'(ADDR_PIN_INPUT_EN);
  wire hit_out  = rd_addr == ADDR_W'(ADDR_PIN0_OUT_CTRL);

  // unmapped addresses read as zero
  wire [7:0] rd_byte =
    hit_rx   ? rx_image :
    hit_io   ? io_image :
    hit_sts  ? pin_levels :
    hit_inen ? input_enable_nxt :
    hit_out  ? out_image : 8'h00;

  wire [31:0] hrdata_nxt = rd_take ? {24'h00_0000, rd_byte} : 32'h0000_0000;

  // device wide status over enabled ports
  wire any_lock  = |(rx_lock & rx_enable_r);
  wire all_pass  = &(rx_pass | ~rx_enable_r);
  wire some_pass = |(rx_pass & rx_enable_r);

  // receive port selected by the low source bits
  wire [1:0] port_idx   = out_source_r[1:0];
  wire [3:0] port_gpio  = rx_remote_gpio[port_idx*4 +: 4];
  wire       port_lock  = rx_lock[port_idx];
  wire       port_pass  = rx_pass[port_idx];
  wire       port_fv    = rx_frame_valid[port_idx];
  wire       port_lv    = rx_line_valid[port_idx];

  logic rx_src_bit;
  logic status_src_bit;
  logic tx_src_bit;
  logic pin0_data;

  always_comb begin
    case (out_select_r)
      3'h0:    rx_src_bit = port_gpio[0];
      3'h1:    rx_src_bit = port_gpio[1];
      3'h2:    rx_src_bit = port_gpio[2];
      3'h3:    rx_src_bit = port_gpio[3];
      3'h4:    rx_src_bit = port_lock;
      3'h5:    rx_src_bit = port_pass;
      3'h6:    rx_src_bit = port_fv;
      3'h7:    rx_src_bit = port_lv;
      default: rx_src_bit = 1'b0;
    endcase
  end

  always_comb begin
    case (out_select_r)
      3'h0:    status_src_bit = out_value_r;
      3'h1:    status_src_bit = any_lock;
      3'h2:    status_src_bit = all_pass;
      3'h3:    status_src_bit = all_pass;
      3'h4:    status_src_bit = frame_sync_pulse;
      default: status_src_bit = 1'b0;
    endcase
  end

  always_comb begin
    case (out_select_r)
      3'h0:    tx_src_bit = all_pass;
      3'h1:    tx_src_bit = some_pass;
      3'h2:    tx_src_bit = tx_frame_valid;
      3'h3:    tx_src_bit = tx_line_valid;
      3'h4:    tx_src_bit = tx_synchronized;
      3'h5:    tx_src_bit = tx_interrupt;
      default: tx_src_bit = 1'b0;
    endcase
  end

  always_comb begin
    case (out_source_r)
      3'h0, 3'h1, 3'h2, 3'h3: pin0_data = rx_src_bit;
      SRC_DEVICE_STATUS:      pin0_data = status_src_bit;
      SRC_TX_PORT0:           pin0_data = tx_src_bit;
      default:                pin0_data = 1'b0;
    endcase
  end

  // bus side flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend_r <= wr_take;
      wr_addr_r <= haddr;
      hrdata    <= hrdata_nxt;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // stored register fields
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_enable_r     <= RST_RX_ENABLE;
      target_select_r <= RST_TARGET_SELECT;
      level_wr_r      <= RST_LEVEL_SELECT;
      override_r      <= RST_OVERRIDE;
      mode_wr_r       <= RST_SUPPLY_MODE;
      input_enable_r  <= RST_INPUT_ENABLE;
    end else begin
      rx_enable_r     <= rx_enable_nxt;
      target_select_r <= target_select_nxt;
      level_wr_r      <= level_wr_nxt;
      override_r      <= override_nxt;
      mode_wr_r       <= mode_wr_nxt;
      input_enable_r  <= input_enable_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_select_r <= RST_OUT_SELECT;
      out_source_r <= RST_OUT_SOURCE;
      out_value_r  <= RST_OUT_VALUE;
      out_enable_r <= RST_OUT_ENABLE;
    end else begin
      out_select_r <= out_select_nxt;
      out_source_r <= out_source_nxt;
      out_value_r  <= out_value_nxt;
      out_enable_r <= out_enable_nxt;
    end
  end

  // control outputs, each straight from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      receiver_enable         <= RST_RX_ENABLE;
      chan_target_port_select <= RST_TARGET_SELECT;
      io_level_select         <= RST_LEVEL_SELECT;
      supply_mode             <= RST_SUPPLY_MODE;
      pin_input_enable        <= RST_INPUT_ENABLE;
      pin0_out                <= 1'b0;
      pin0_oe                 <= 1'b0;
    end else begin
      receiver_enable         <= rx_enable_nxt;
      chan_target_port_select <= target_select_nxt;
      io_level_select         <= level_eff_nxt;
      supply_mode             <= mode_eff_nxt;
      pin_input_enable        <= input_enable_nxt;
      pin0_out                <= out_enable_r & pin0_data;
      pin0_oe                 <= out_enable_r;
    end
  end

endmodule

// file: inc/hub_port_io_pkg.sv
// constants for the receiver port, io supply and gpio control block
package hub_port_io_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_RX_PORT_CTRL   = 8'h0c;
  localparam logic [7:0] IDX_IO_SUPPLY_CTRL = 8'h0d;
  localparam logic [7:0] IDX_PIN_LEVEL_STS  = 8'h0e;
  localparam logic [7:0] IDX_PIN_INPUT_EN   = 8'h0f;
  localparam logic [7:0] IDX_PIN0_OUT_CTRL  = 8'h10;

  localparam logic [7:0] ADDR_RX_PORT_CTRL   = 8'h30;
  localparam logic [7:0] ADDR_IO_SUPPLY_CTRL = 8'h34;
  localparam logic [7:0] ADDR_PIN_LEVEL_STS  = 8'h38;
  localparam logic [7:0] ADDR_PIN_INPUT_EN   = 8'h3c;
  localparam logic [7:0] ADDR_PIN0_OUT_CTRL  = 8'h40;

  // reset values, and the fixed value of the io reserved bits
  localparam logic [3:0] RST_RX_ENABLE      = 4'hf;
  localparam logic [3:0] RST_TARGET_SELECT  = 4'h0;
  localparam logic       RST_LEVEL_SELECT   = 1'b0;
  localparam logic       RST_OVERRIDE       = 1'b0;
  localparam logic [1:0] RST_SUPPLY_MODE    = 2'h0;
  localparam logic [3:0] IO_RESERVED_VALUE  = 4'h9;
  localparam logic [7:0] RST_INPUT_ENABLE   = 8'hff;
  localparam logic [2:0] RST_OUT_SELECT     = 3'h0;
  localparam logic [2:0] RST_OUT_SOURCE     = 3'h0;
  localparam logic       RST_OUT_VALUE      = 1'b0;
  localparam logic       RST_OUT_ENABLE     = 1'b0;

  // field positions
  localparam int TGT_SEL_LSB  = 4;
  localparam int RX_EN_LSB    = 0;
  localparam int LEVEL_BIT    = 7;
  localparam int OVERRIDE_BIT = 6;
  localparam int MODE_LSB     = 4;
  localparam int OUT_SEL_LSB  = 5;
  localparam int OUT_SRC_LSB  = 2;
  localparam int OUT_VAL_BIT  = 1;
  localparam int OUT_EN_BIT   = 0;

  // supply mode encodings
  localparam logic [1:0] MODE_1V8 = 2'h0;
  localparam logic [1:0] MODE_3V3 = 2'h3;

  // output source codes
  localparam logic [2:0] SRC_DEVICE_STATUS = 3'h4;
  localparam logic [2:0] SRC_TX_PORT0      = 3'h6;

  // ahb transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;

endpackage

// file: tb/hub_port_io_asserts.sv
// bound checker for the port, io supply and gpio0 control block
`timescale 1ns/1ps
module hub_port_io_chk
  import hub_port_io_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic [31:0]       hrdata,
  input wire logic              io_level_detected,
  input wire logic [7:0]        pin_in,
  input wire logic [3:0]        receiver_enable,
  input wire logic [3:0]        chan_target_port_select,
  input wire logic              io_level_select,
  input wire logic [1:0]        supply_mode,
  input wire logic [7:0]        pin_input_enable,
  input wire logic              pin0_out,
  input wire logic              pin0_oe
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // a transfer is taken on this edge
  wire logic take = hsel && hready && htrans[1];

  a_rx_ctrl_write: assert property (
    take && hwrite && haddr == ADDR_RX_PORT_CTRL |=> ##1
    {chan_target_port_select, receiver_enable} == $past(hwdata[7:0]))
    else $error("receiver port control not written");
  a_in_en_write: assert property (
    take && hwrite && haddr == ADDR_PIN_INPUT_EN |=> ##1
    pin_input_enable == $past(hwdata[7:0]))
    else $error("input enable not written");
  a_status_read: assert property (
    take && !hwrite && haddr == ADDR_PIN_LEVEL_STS |=>
    hrdata[7:0] == ($past(pin_in) & $past(pin_input_enable)))
    else $error("pin status read wrong");
  a_io_reserved: assert property (
    take && !hwrite && haddr == ADDR_IO_SUPPLY_CTRL |=> hrdata[3:0] == 4'h9)
    else $error("io control low bits wrong");
  a_reset_values: assert property (
    $rose(hresetn) |-> receiver_enable == 4'hf && pin_input_enable == 8'hff
    && chan_target_port_select == 4'h0 && !pin0_oe)
    else $error("reset values wrong");
  a_level_follow: assert property (
    $rose(hresetn) |=> io_level_select == $past(io_level_detected)
    && supply_mode == {2{$past(io_level_detected)}})
    else $error("supply level not following detection");
  a_oe_gate: assert property (
    take && hwrite && haddr == ADDR_PIN0_OUT_CTRL |=> ##2
    pin0_oe == $past(hwdata[0], 2) && (pin0_oe || !pin0_out))
    else $error("pin0 enable not following write");
  a_pin0_local: assert property (
    take && hwrite && haddr == ADDR_PIN0_OUT_CTRL ##1 hwdata[7:2] == 6'h04
    |=> ##1 pin0_out == ($past(hwdata[1], 2) & $past(hwdata[0], 2))
    && pin0_oe == $past(hwdata[0], 2))
    else $error("pin0 local value wrong");
endmodule

bind hub_port_io_gpio_ctrl hub_port_io_chk #(.ADDR_W(ADDR_W)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .io_level_detected(io_level_detected), .pin_in(pin_in),
  .receiver_enable(receiver_enable),
  .chan_target_port_select(chan_target_port_select),
  .io_level_select(io_level_select), .supply_mode(supply_mode),
  .pin_input_enable(pin_input_enable), .pin0_out(pin0_out),
  .pin0_oe(pin0_oe));

// file: tb/tb_top.sv
// self-checking bench for the port, io supply and gpio0 control block
`timescale 1ns/1ps
module tb_top;
  import hub_port_io_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, io_det;
  logic        fsync, tx_fv, tx_lv, tx_sync, tx_int, lvl_sel, p0_out, p0_oe;
  logic [7:0]  haddr, pin_in, in_en;
  logic [1:0]  htrans, mode;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [15:0] remote;
  logic [3:0]  lock, pass, fv, lv, rx_en, chan, ren;
  int          failures, compares, p, i;

  hub_port_io_gpio_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .io_level_detected(io_det),
    .pin_in(pin_in), .rx_remote_gpio(remote), .rx_lock(lock),
    .rx_pass(pass), .rx_frame_valid(fv), .rx_line_valid(lv),
    .frame_sync_pulse(fsync), .tx_frame_valid(tx_fv), .tx_line_valid(tx_lv),
    .tx_synchronized(tx_sync), .tx_interrupt(tx_int),
    .receiver_enable(rx_en), .chan_target_port_select(chan),
    .io_level_select(lvl_sel), .supply_mode(mode),
    .pin_input_enable(in_en), .pin0_out(p0_out), .pin0_oe(p0_oe));

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  task close_out;
    if (failures == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task wait_rdy;
    int n;
    for (n = 0; n < 16; n++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) break;
    end
    if (n == 16) begin
      failures++;
      $display("wrong value at %0t: no ready from slave", $time);
      close_out();
    end
  endtask

  task xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy();
    rd = hrdata;
    chk({7'h0, hresp}, 8'h00);
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task rchk(input logic [7:0] a, input logic [7:0] exp);
    xfer(a, 1'b0, 8'h0);
    chk(rd[7:0], exp);
  endtask

  // expected gpio0 data for a source and select, from the live inputs
  function automatic logic mux_exp(input logic [2:0] src,
                                   input logic [2:0] sel,
                                   input logic       v);
    logic [3:0] ps;
    ps = pass | ~ren;
    if (!src[2]) begin
      case (sel)
        3'h4: return lock[src[1:0]];
        3'h5: return pass[src[1:0]];
        3'h6: return fv[src[1:0]];
        3'h7: return lv[src[1:0]];
        default: return remote[{src[1:0], sel[1:0]}];
      endcase
    end
    if (src == SRC_DEVICE_STATUS) begin
      case (sel)
        3'h0: return v;
        3'h1: return |(lock & ren);
        3'h2, 3'h3: return &ps;
        3'h4: return fsync;
        default: return 1'b0;
      endcase
    end
    if (src == SRC_TX_PORT0) begin
      case (sel)
        3'h0: return &ps;
        3'h1: return |(pass & ren);
        3'h2: return tx_fv;
        3'h3: return tx_lv;
        3'h4: return tx_sync;
        3'h5: return tx_int;
        default: return 1'b0;
      endcase
    end
    return 1'b0;
  endfunction

  initial begin
    {hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
    {remote, lock, pass, fv, lv, fsync, tx_fv, tx_lv, tx_sync, tx_int} = '0;
    hsize = 3'h2;
    io_det = 1'b1;
    pin_in = 8'ha5;
    ren = 4'h5;
    failures = 0;
    compares = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(ADDR_RX_PORT_CTRL, 8'h0f);
    rchk(ADDR_IO_SUPPLY_CTRL, 8'hb9);
    rchk(ADDR_PIN_INPUT_EN, 8'hff);
    rchk(ADDR_PIN0_OUT_CTRL, 8'h00);
    rchk(ADDR_PIN_LEVEL_STS, 8'ha5);
    xfer(ADDR_RX_PORT_CTRL, 1'b1, 8'ha5);
    rchk(ADDR_RX_PORT_CTRL, 8'ha5);
    chk({chan, rx_en}, 8'ha5);
    xfer(ADDR_IO_SUPPLY_CTRL, 1'b1, 8'h4f);
    rchk(ADDR_IO_SUPPLY_CTRL, 8'h49);
    chk({5'h0, lvl_sel, mode}, 8'h00);
    xfer(ADDR_IO_SUPPLY_CTRL, 1'b1, 8'hf0);
    rchk(ADDR_IO_SUPPLY_CTRL, 8'hf9);
    chk({5'h0, lvl_sel, mode}, 8'h07);
    xfer(ADDR_IO_SUPPLY_CTRL, 1'b1, 8'hb0);
    io_det <= 1'b0;
    rchk(ADDR_IO_SUPPLY_CTRL, 8'h09);
    chk({5'h0, lvl_sel, mode}, 8'h00);
    xfer(ADDR_PIN_INPUT_EN, 1'b1, 8'h0f);
    xfer(ADDR_PIN_LEVEL_STS, 1'b1, 8'hff);
    rchk(ADDR_PIN_LEVEL_STS, 8'h05);
    chk(in_en, 8'h0f);
    xfer(8'h44, 1'b1, 8'hff);
    rchk(8'h44, 8'h00);
    for (p = 0; p < 2; p++) begin
      {remote, lock, pass, fv, lv, fsync, tx_fv, tx_lv, tx_sync, tx_int} <=
        {37{p[0]}} ^ {16'h5a3c, 16'h6b5c, 5'h15};
      for (i = 0; i < 64; i++) begin
        xfer(ADDR_PIN0_OUT_CTRL, 1'b1, {i[5:0], p[0], 1'b1});
        repeat (2) @(posedge hclk);
        chk({7'h0, p0_out},
            {7'h0, mux_exp(i[2:0], i[5:3], p[0])});
      end
    end
    xfer(ADDR_PIN0_OUT_CTRL, 1'b1, 8'h12);
    repeat (2) @(posedge hclk);
    chk({6'h0, p0_oe, p0_out}, 8'h00);
    close_out();
  end
endmodule
